// ### pkg/pin_mux_pkg.sv
// Constants for the lock / serial-out pin source selector
package pin_mux_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 24;
    localparam int SEL_W  = 5;
    localparam int NUM_SOURCES = 32;

    localparam logic [ADDR_W-1:0] CTRL_OFFSET = 6'h0F;
    localparam logic [DATA_W-1:0] CTRL_RESET  = 24'h000001;

    localparam int SEL_LSB       = 0;
    localparam int TEST_DATA_BIT = 5;
    localparam int BLOCK_AUTO_BIT = 6;
    localparam int KEEP_ON_BIT   = 7;
    localparam int HS_OFF_BIT    = 8;

    localparam logic [SEL_W-1:0] SRC_TEST_DATA     = 5'h00;
    localparam logic [SEL_W-1:0] SRC_LOCK          = 5'h01;
    localparam logic [SEL_W-1:0] SRC_LOCK_TRIGGER  = 5'h02;
    localparam logic [SEL_W-1:0] SRC_LOCK_WINDOW   = 5'h03;
    localparam logic [SEL_W-1:0] SRC_RING_OSC      = 5'h04;
    localparam logic [SEL_W-1:0] SRC_PULL_UP       = 5'h05;
    localparam logic [SEL_W-1:0] SRC_PULL_DOWN     = 5'h06;
    localparam logic [SEL_W-1:0] SRC_RESERVED      = 5'h07;
    localparam logic [SEL_W-1:0] SRC_REF_BUFFER    = 5'h08;
    localparam logic [SEL_W-1:0] SRC_REF_DIVIDER   = 5'h09;
    localparam logic [SEL_W-1:0] SRC_OSC_DIVIDER   = 5'h0A;
    localparam logic [SEL_W-1:0] SRC_MOD_CLOCK     = 5'h0B;
    localparam logic [SEL_W-1:0] SRC_AUX_CLOCK_A   = 5'h0C;
    localparam logic [SEL_W-1:0] SRC_AUX_CLOCK_B   = 5'h0D;
    localparam logic [SEL_W-1:0] SRC_AUX_ENABLE    = 5'h0E;
    localparam logic [SEL_W-1:0] SRC_AUX_DATA      = 5'h0F;
    localparam logic [SEL_W-1:0] SRC_PD_DOWN       = 5'h10;
    localparam logic [SEL_W-1:0] SRC_PD_UP         = 5'h11;
    localparam logic [SEL_W-1:0] SRC_SD_CLK_DELAY  = 5'h12;
    localparam logic [SEL_W-1:0] SRC_SD_CORE_CLK   = 5'h13;
    localparam logic [SEL_W-1:0] SRC_STROBE_INT    = 5'h14;
    localparam logic [SEL_W-1:0] SRC_STROBE_FRAC   = 5'h15;
    localparam logic [SEL_W-1:0] SRC_STROBE_AUX    = 5'h16;
    localparam logic [SEL_W-1:0] SRC_LATCH_ENABLE  = 5'h17;
    localparam logic [SEL_W-1:0] SRC_DIV_SYNC_RST  = 5'h18;
    localparam logic [SEL_W-1:0] SRC_SEED_LOAD     = 5'h19;
    localparam logic [SEL_W-1:0] SRC_UNUSED_FIRST  = 5'h1A;
    localparam logic [SEL_W-1:0] SRC_UNUSED_LAST   = 5'h1D;
    localparam logic [SEL_W-1:0] SRC_OUT_BUF_EN    = 5'h1E;
    localparam logic [SEL_W-1:0] SRC_SOFT_RESET    = 5'h1F;
endpackage

// ### pkg/ctrl_if.sv
// Carrier between the control register and the pin selector
interface ctrl_if;
    import pin_mux_pkg::*;
    logic                  wr_en;
    logic [DATA_W-1:0]     wr_data;
    logic [DATA_W-1:0]     value;

    modport store (
        input  wr_en,
        input  wr_data,
        output value
    );
    modport user (
        output wr_en,
        output wr_data,
        input  value
    );
endinterface

// ### src/ctrl_register.sv
// Output pin and divider control register storage
module ctrl_register (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Register port
    ctrl_if.store     ctrl
);
    import pin_mux_pkg::*;

    logic [DATA_W-1:0] value_reg;
    logic [DATA_W-1:0] value_next;

    // Whole word is written; upper divider bits are only stored here
    assign value_next = ctrl.wr_en ? ctrl.wr_data : value_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            value_reg <= CTRL_RESET; // RQ1 RQ12
        end else begin
            value_reg <= value_next;
        end
    end

    assign ctrl.value = value_reg;
endmodule // ctrl_register

// ### src/lock_serial_pin_output_mux.sv
// Source selector and driver control for the lock / serial-out pin
//
// Function
// RQ1: Five-bit source select in bits 4:0, reset 1, drives enabled pin.
// RQ2: Code 0 drives the software test-data bit onto the pin.
// RQ3: Codes 1-3 lock, trigger, window; code 4 ring-oscillator test.
// RQ4: Codes 5 and 6 attach weak pull-up or pull-down; 7 reserved.
// RQ5: Codes 8-11 reference buffer, reference divider, divider, mod clock.
// RQ6: Codes 12-15 expose auxiliary serial clock, enable and data.
// RQ7: Codes 16 and 17 give phase-detector down and up pulses.
// RQ8: Codes 18 and 19 give modulator delayed clock and core clock.
// RQ9: Codes 20-22 give integer, fractional and auxiliary write strobes.
// RQ10: Codes 23-25 give latch enable, divider sync reset, seed load.
// RQ11: Codes 26-29 unused; 30 output-buffer enable; 31 soft reset.
// RQ12: Read/write test-data bit at position 5, reset 0.
// RQ13: Bit 6 clear auto-switches to serial read data; set blocks it.
// RQ14: Bit 7 set keeps driver on; clear drives only during reads.
// RQ15: Bit 8 set disables the pin's high-side drive.
// RQ16: Unused or reserved codes drive constant low.
module lock_serial_pin_output_mux #(
    parameter int SYNC_STAGES = 2
) (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         reset,
    // Serial-port register access
    input  wire logic                         reg_wr_en,
    input  wire logic [pin_mux_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [pin_mux_pkg::DATA_W-1:0] reg_wr_data,
    output logic      [pin_mux_pkg::DATA_W-1:0] reg_rd_data,
    // Serial read cycle from the serial port
    input  wire logic                         serial_read_active,
    input  wire logic                         serial_read_data,
    // Internal signal sources, bit index equals select code
    input  wire logic [pin_mux_pkg::NUM_SOURCES-1:0] internal_sources,
    // Pin driver
    output logic                              pin_out,
    output logic                              pin_oe,
    output logic                              pull_up_en,
    output logic                              pull_down_en,
    output logic                              high_side_disable
);
    import pin_mux_pkg::*;

    ctrl_if ctrl ();

    ctrl_register u_ctrl_register (
        .clk   (clk),
        .reset (reset),
        .ctrl  (ctrl.store)
    );

    // Register decode
    wire addr_hit = (reg_addr == CTRL_OFFSET);

    assign ctrl.wr_en   = reg_wr_en & addr_hit;
    assign ctrl.wr_data = reg_wr_data;

    logic [DATA_W-1:0] rd_data_reg;
    logic [DATA_W-1:0] rd_data_next;

    // Unmapped addresses read as zero
    assign rd_data_next = addr_hit ? ctrl.value : '0;

    // Control fields
    wire [SEL_W-1:0] output_pin_source_select =
        ctrl.value[SEL_LSB +: SEL_W];                    // RQ1
    wire general_purpose_output = ctrl.value[TEST_DATA_BIT]; // RQ12
    wire block_auto_switch      = ctrl.value[BLOCK_AUTO_BIT];
    wire pin_driver_keep_on     = ctrl.value[KEEP_ON_BIT];
    wire high_side_off          = ctrl.value[HS_OFF_BIT];

    // Sources come from other clock domains; two flops before any use.
    // Fast clocks are aliased at this rate, the pin sees a sampled copy.
    logic [NUM_SOURCES-1:0] sync_stage [SYNC_STAGES];
    logic [NUM_SOURCES-1:0] sync_in    [SYNC_STAGES];

    genvar g;
    generate
        for (g = 0; g < SYNC_STAGES; g++) begin : g_sync
            // First stage alone sees the raw inputs; no out-of-range index
            if (g == 0) begin : g_first
                assign sync_in[g] = internal_sources;
            end else begin : g_later
                assign sync_in[g] = sync_stage[g-1];
            end
            always_ff @(posedge clk) begin
                if (reset) begin
                    sync_stage[g] <= '0;
                end else begin
                    sync_stage[g] <= sync_in[g];
                end
            end
        end
    endgenerate

    wire [NUM_SOURCES-1:0] sources_sync = sync_stage[SYNC_STAGES-1];

    // Codes that do not carry a live internal signal
    wire code_is_pull = (output_pin_source_select == SRC_PULL_UP) ||
                        (output_pin_source_select == SRC_PULL_DOWN);
    wire code_unused  = (output_pin_source_select == SRC_RESERVED) ||
                        ((output_pin_source_select >= SRC_UNUSED_FIRST) &&
                         (output_pin_source_select <= SRC_UNUSED_LAST));
    wire code_is_test = (output_pin_source_select == SRC_TEST_DATA);

    // RQ3 RQ5 RQ6 RQ7 RQ8 RQ9 RQ10 RQ11: code indexes the source vector
    wire live_source = sources_sync[output_pin_source_select];

    wire selected_value =
        code_is_test ? general_purpose_output :          // RQ2
        (code_is_pull || code_unused) ? 1'b0 :           // RQ4 RQ16
        live_source;

    // Read data replaces the selected output during a read cycle unless bit 6 blocks it
    wire use_read_data = serial_read_active & ~block_auto_switch; // RQ13
    wire pin_value = use_read_data ? serial_read_data : selected_value;

    // Driver enable policy
    wire driver_enabled = pin_driver_keep_on | serial_read_active; // RQ14

    // Pull codes connect the resistor, not the active driver
    wire active_drive = driver_enabled &
                        ~(code_is_pull & ~use_read_data);   // RQ4

    // Without high side only a low level is actively driven
    wire oe_next = active_drive & ~(high_side_off & pin_value); // RQ15

    wire pull_up_next   = driver_enabled & ~use_read_data &
                          (output_pin_source_select == SRC_PULL_UP);
    wire pull_down_next = driver_enabled & ~use_read_data &
                          (output_pin_source_select == SRC_PULL_DOWN);

    logic pin_out_reg;
    logic pin_oe_reg;
    logic pull_up_reg;
    logic pull_down_reg;
    logic hs_disable_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            pin_out_reg    <= 1'b0;
            pin_oe_reg     <= 1'b0;
            pull_up_reg    <= 1'b0;
            pull_down_reg  <= 1'b0;
            hs_disable_reg <= 1'b0;
            rd_data_reg    <= '0;
        end else begin
            pin_out_reg    <= pin_value;      // RQ1
            pin_oe_reg     <= oe_next;        // RQ14
            pull_up_reg    <= pull_up_next;   // RQ4
            pull_down_reg  <= pull_down_next; // RQ4
            hs_disable_reg <= high_side_off;  // RQ15
            rd_data_reg    <= rd_data_next;
        end
    end

    assign pin_out           = pin_out_reg;
    assign pin_oe            = pin_oe_reg;
    assign pull_up_en        = pull_up_reg;
    assign pull_down_en      = pull_down_reg;
    assign high_side_disable = hs_disable_reg;
    assign reg_rd_data       = rd_data_reg;
endmodule // lock_serial_pin_output_mux

// ### sim/pin_mux_checker.sv
// Port checker for the lock / serial-out pin selector
module pin_mux_checker (
    input wire logic        clk, reset, reg_wr_en,
    input wire logic [5:0]  reg_addr,
    input wire logic [23:0] reg_wr_data, reg_rd_data,
    input wire logic        serial_read_active, serial_read_data,
    input wire logic [31:0] internal_sources,
    input wire logic        pin_out, pin_oe, pull_up_en, pull_down_en,
    input wire logic        high_side_disable
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [23:0] sh;
    logic [1:0]  age;
    wire         ok = age == 2'd3;
    wire         use_rd = serial_read_active & ~sh[6];
    wire [4:0]   cd = sh[4:0];
    wire         pull = cd == 5'h05 || cd == 5'h06;
    // Outputs sit low one edge past reset, so checks wait a little
    always_ff @(posedge clk) begin
        if (reset) begin
            sh  <= 24'h000001;
            age <= 2'd0;
        end else begin
            if (reg_wr_en && reg_addr == 6'h0F) sh <= reg_wr_data;
            if (!ok) age <= age + 2'd1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_read_back: assert property (ok && $past(reg_addr) == 6'h0F
        |-> reg_rd_data == $past(sh)) else $error("read back wrong");
    a_unmapped_zero: assert property (ok && $past(reg_addr) != 6'h0F
        |-> reg_rd_data == 24'h0) else $error("unmapped read not 0");
    a_idle_off: assert property (ok && $past(!sh[7] && !serial_read_active)
        |-> !pin_oe && !pull_up_en && !pull_down_en) else $error("idle drive");
    a_read_pass: assert property (ok && $past(use_rd)
        |-> pin_out == $past(serial_read_data)
        && pin_oe == !(high_side_disable && pin_out)) else $error("read path");
    a_test_bit: assert property (ok && $past(cd == 5'h00 && !use_rd)
        |-> pin_out == $past(sh[5])) else $error("test bit not shown");
    a_unused_low: assert property (ok && $past(!use_rd
        && cd inside {5'h07, [5'h1A:5'h1D]}) |-> !pin_out)
        else $error("unused code not low");
    a_pull_attach: assert property (ok && $past(sh[7] && !use_rd && pull)
        |-> !pin_oe && pull_up_en == $past(cd == 5'h05)
        && pull_down_en == $past(cd == 5'h06)) else $error("pull wrong");
    a_keep_on: assert property (ok && $past(sh[7] && !use_rd && !pull)
        |-> pin_oe == !(high_side_disable && pin_out)) else $error("keep on");
    // Code must hold over the whole sync latency, else old and new mix
    a_src_route: assert property (
        (ok && !use_rd && $stable(cd)
        && cd inside {[5'h01:5'h04], [5'h08:5'h19], 5'h1E, 5'h1F})[*4]
        |-> pin_out == $past(internal_sources[cd], 3))
        else $error("routing");
    a_hs_copy: assert property (ok |-> high_side_disable == $past(sh[8]))
        else $error("high side flag");
endmodule // pin_mux_checker

bind lock_serial_pin_output_mux pin_mux_checker u_pin_mux_checker (.*);

// ### sim/pin_board_model.sv
// Board side of the pin: resolves the wire level from all drivers
module pin_board_model (
    input wire logic clk, pin_out, pin_oe, pull_up_en, pull_down_en,
    output logic     level
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last = 1'b0;
    // Undriven, unpulled wire toggles so a stale value never looks valid
    always_comb level = pin_oe ? pin_out : pull_up_en ? 1'b1
                      : pull_down_en ? 1'b0 : ~last;
    always_ff @(posedge clk) last <= level;
endmodule // pin_board_model

// ### sim/lock_serial_pin_output_mux_bench.sv
// Self-checking bench for the lock / serial-out pin selector
module lock_serial_pin_output_mux_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, reset = 1'b1, reg_wr_en = 1'b0;
    logic [5:0]  reg_addr = 6'h0F;
    logic [23:0] reg_wr_data = 24'h0, reg_rd_data;
    logic        serial_read_active = 1'b0, serial_read_data = 1'b0;
    logic [31:0] internal_sources = 32'h0;
    logic        pin_out, pin_oe, pull_up_en, pull_down_en;
    logic        high_side_disable, level;
    int          fails = 0, total_checks = 0;
    lock_serial_pin_output_mux u_lock_serial_pin_output_mux (.*);
    pin_board_model u_pin_board_model (.*);
    always #50 clk = ~clk;
    task automatic chk(string n, logic [23:0] e, logic [23:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic pins(logic [3:0] e);
        chk("pins", e, {pin_out, pin_oe, pull_up_en, pull_down_en});
    endtask
    task automatic wr(logic [5:0] a, logic [23:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        @(negedge clk);
        reg_wr_en = 1'b0;
        reg_addr = 6'h0F;
        repeat (2) @(negedge clk);
    endtask
    task automatic rd(logic [5:0] a, logic [23:0] e);
        @(negedge clk);
        reg_addr = a;
        @(negedge clk);
        chk("rd_data", e, reg_rd_data);
        reg_addr = 6'h0F;
    endtask
    task automatic src(logic [31:0] v);
        @(negedge clk);
        internal_sources = v;
        repeat (4) @(negedge clk);
    endtask
    task automatic t_regs;
        rd(6'h0F, 24'h000001);
        wr(6'h0F, 24'hA5A4A0);
        rd(6'h0F, 24'hA5A4A0);
        pins(4'b1100);
        wr(6'h21, 24'hFFFFFF);
        rd(6'h21, 24'h000000);
        rd(6'h0F, 24'hA5A4A0);
    endtask
    task automatic t_test_bit;
        wr(6'h0F, 24'h000080);
        pins(4'b0100);
        wr(6'h0F, 24'h000020);
        chk("pin_oe", 1'b0, pin_oe);
    endtask
    task automatic t_sources;
        bit ok;
        for (int c = 1; c < 32; c++) begin
            if (c == 5 || c == 6) continue;
            ok = !(c == 7 || (c >= 26 && c <= 29));
            wr(6'h0F, 24'h80 | 24'(c));
            src(32'h1 << c);
            chk("src_hi", {ok, 1'b1}, {pin_out, pin_oe});
            src(~(32'h1 << c));
            chk("src_lo", 2'b01, {pin_out, pin_oe});
        end
    endtask
    task automatic t_pulls;
        wr(6'h0F, 24'h000085);
        pins(4'b0010);
        chk("level", 1'b1, level);
        wr(6'h0F, 24'h000086);
        pins(4'b0001);
        chk("level", 1'b0, level);
        wr(6'h0F, 24'h000005);
        pins(4'b0000);
    endtask
    task automatic t_read;
        wr(6'h0F, 24'h000000);
        serial_read_active = 1'b1;
        serial_read_data = 1'b1;
        @(negedge clk);
        pins(4'b1100);
        chk("level", 1'b1, level);
        wr(6'h0F, 24'h000040);
        pins(4'b0100);
        serial_read_active = 1'b0;
        @(negedge clk);
        chk("pin_oe", 1'b0, pin_oe);
    endtask
    task automatic t_high_side;
        wr(6'h0F, 24'h0001A0);
        pins(4'b1000);
        chk("hs_off", 1'b1, high_side_disable);
        wr(6'h0F, 24'h000180);
        pins(4'b0100);
    endtask
    task automatic finish_test;
        if (fails == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk);
        reset = 1'b0;
        t_regs;
        t_test_bit;
        t_sources;
        t_pulls;
        t_read;
        t_high_side;
        finish_test;
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge clk);
        fails++;
        finish_test;
    end
endmodule // lock_serial_pin_output_mux_bench
